// *** pdsd_regs.svh ***
// constants for the peripheral detect and soft detach sequencer
`ifndef PDSD_REGS_SVH
`define PDSD_REGS_SVH
`define PDSD_CLK_MHZ 200
`define PDSD_DETACH_MS 50
`define PDSD_DETACH_CYC (`PDSD_DETACH_MS * 1000 * `PDSD_CLK_MHZ)
`define PDSD_RX_TO_US 2000
`define PDSD_RX_TO_CYC (`PDSD_RX_TO_US * `PDSD_CLK_MHZ)
`define PDSD_INHIBIT_US 100
`define PDSD_INHIBIT_CYC (`PDSD_INHIBIT_US * `PDSD_CLK_MHZ)
`define PDSD_TIMER_W 24
`define PDSD_FRAME_LAST 4'd10
`define PDSD_CMD_IDENTIFY 8'hf2
`define PDSD_RSP_ACK 8'hfa
`define PDSD_ADDR_W 10
`define PDSD_MS_DEV_ADDR 10'h000
`define PDSD_KB_DEV_ADDR 10'h020
`define PDSD_MS_CFG_ADDR 10'h040
`define PDSD_KB_CFG_ADDR 10'h080
`define PDSD_MS_RPT_ADDR 10'h0c0
`define PDSD_KB_RPT_ADDR 10'h100
`define PDSD_STR_BASE 10'h180
`define PDSD_STR_SHIFT 5
`define PDSD_DEV_LEN 8'h12
`define PDSD_MS_CFG_LEN 8'h22
`define PDSD_KB_CFG_LEN 8'h22
`define PDSD_MS_RPT_LEN 8'h32
`define PDSD_KB_RPT_LEN 8'h3f
`define PDSD_STR_LEN 8'h20
`define PDSD_STR_MAX 4'ha
`endif

// *** pdsd_pkg.sv ***
// types shared by the sequencer and its descriptor fifo
package pdsd_pkg;
  typedef enum logic [1:0] {
    PDSD_DESC_DEVICE = 2'b00,
    PDSD_DESC_CONFIG = 2'b01,
    PDSD_DESC_REPORT = 2'b10,
    PDSD_DESC_STRING = 2'b11
  } pdsd_desc_kind_t;

  typedef struct packed {
    logic last;
    logic [9:0] addr;
  } pdsd_desc_word_t;

  typedef enum logic [3:0] {
    PDSD_ST_IDLE = 4'b0000,
    PDSD_ST_RX = 4'b0001,
    PDSD_ST_WAIT_ATT = 4'b0010,
    PDSD_ST_INHIBIT = 4'b0011,
    PDSD_ST_TX = 4'b0100,
    PDSD_ST_RX_ACK = 4'b0101,
    PDSD_ST_RX_ID0 = 4'b0110,
    PDSD_ST_RX_ID1 = 4'b0111,
    PDSD_ST_DETACH = 4'b1000,
    PDSD_ST_REINIT = 4'b1001
  } pdsd_state_t;
endpackage : pdsd_pkg

// *** pdsd_fifo.sv ***
// small synchronous fifo with valid and ready on both sides
`timescale 1ns/1ps
module pdsd_fifo #(
  parameter int W = 11,
  parameter int D = 16,
  parameter int AW = $clog2(D)
) (
  input wire logic clk_sys_in,
  input wire logic arst_n_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [W-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [W-1:0] out_data_out
);
  logic [W-1:0] mem_ff [D];
  logic [AW:0] wr_ff;
  logic [AW:0] rd_ff;
  wire full = (wr_ff[AW] != rd_ff[AW]) && (wr_ff[AW-1:0] == rd_ff[AW-1:0]);
  wire empty = (wr_ff == rd_ff);
  wire push = in_valid_in && !full;
  wire pop = out_ready_in && !empty;

  // ready and valid stay honest so a stalled drain backs up into the source
  assign in_ready_out = !full;
  assign out_valid_out = !empty;
  assign out_data_out = mem_ff[rd_ff[AW-1:0]];

  // storage needs no reset, only the pointers define the contents
  always_ff @(posedge clk_sys_in) begin
    if (push) begin
      mem_ff[wr_ff[AW-1:0]] <= in_data_in;
    end
  end

  // pointers carry one extra bit to tell full from empty
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wr_ff <= '0;
      rd_ff <= '0;
    end else begin
      if (push) wr_ff <= wr_ff + 1'b1;
      if (pop) rd_ff <= rd_ff + 1'b1;
    end
  end
endmodule : pdsd_fifo

// *** pdsd_top.sv ***
// peripheral detect, identify and usb soft detach sequencer with descriptor address server
// Contract
// - a soft detach starts by clearing the usb attach enable so the host sees a removal.
// - the attach enable stays cleared for about 50 ms and is then set again.
// - in the same cycle as it reconnects, the usb interface is reinitialised and the host is left to enumerate.
// - a falling port data line while idle raises an event pulse.
// - that falling data line starts a frame reception, as a start bit or as a removal.
// - a reception that times out with data still low means unplugged and enters wait-for-attach.
// - in wait-for-attach a new peripheral is seen when port clock and data are both high.
// - an attached peripheral gets an identify request and the reply drives a soft detach as that type.
// - a keyboard-present flag, high only with a keyboard, selects the descriptor set.
// - device, configuration and report requests pick the set's start address and step it to the end.
// - string requests ignore the flag, the two sets owning disjoint low and high indexes.
`timescale 1ns/1ps
`include "pdsd_regs.svh"
module pdsd_top #(
  parameter int unsigned DETACH_CYC = `PDSD_DETACH_CYC,
  parameter int unsigned RX_TO_CYC = `PDSD_RX_TO_CYC,
  parameter int unsigned INHIBIT_CYC = `PDSD_INHIBIT_CYC,
  parameter logic [7:0] KBD_ID0 = 8'h5a, // arbitrary value
  parameter logic [7:0] KBD_ID1 = 8'h3c, // arbitrary value
  parameter int FIFO_DEPTH = 16
) (
  input wire logic clk_sys_in,
  input wire logic arst_n_in,
  input wire logic port_clk_in,
  output logic port_clk_out,
  output logic port_clk_oe_out,
  input wire logic port_dat_in,
  output logic port_dat_out,
  output logic port_dat_oe_out,
  output logic usb_attach_enable_out,
  output logic usb_interface_init_out,
  output logic data_fall_event_out,
  output logic keyboard_present_flag_out,
  input wire logic desc_req_valid_in,
  output logic desc_req_ready_out,
  input wire pdsd_pkg::pdsd_desc_kind_t desc_req_kind_in,
  input wire logic [3:0] desc_req_index_in,
  output logic desc_valid_out,
  input wire logic desc_ready_in,
  output logic [`PDSD_ADDR_W-1:0] desc_addr_out,
  output logic desc_last_out
);
  localparam int TW = `PDSD_TIMER_W;

  // pin synchronisers, stage one is only read by stage two
  logic clk_s1_ff, clk_s2_ff, clk_d_ff;
  logic dat_s1_ff, dat_s2_ff, dat_d_ff;
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      {clk_s1_ff, clk_s2_ff, clk_d_ff} <= 3'h7;
      {dat_s1_ff, dat_s2_ff, dat_d_ff} <= 3'h7;
    end else begin
      {clk_s1_ff, clk_s2_ff, clk_d_ff} <= {port_clk_in, clk_s1_ff, clk_s2_ff};
      {dat_s1_ff, dat_s2_ff, dat_d_ff} <= {port_dat_in, dat_s1_ff, dat_s2_ff};
    end
  end
  wire clk_fall = clk_d_ff && !clk_s2_ff;
  wire dat_fall = dat_d_ff && !dat_s2_ff;

  pdsd_pkg::pdsd_state_t state_ff, nxt_state;
  logic [TW-1:0] timer_ff;
  logic [3:0] bitcnt_ff, nxt_bitcnt;
  logic [10:0] sh_ff, nxt_sh;
  logic [7:0] id0_ff, nxt_id0;
  logic attach_ff, nxt_attach;
  logic init_ff, nxt_init;
  logic event_ff, nxt_event;
  logic kbd_ff, nxt_kbd;
  logic clk_oe_ff, nxt_clk_oe;
  logic dat_oe_ff, nxt_dat_oe;

  // frame reception shifts in lsb first on each falling port clock
  wire [10:0] rx_shift = {dat_s2_ff, sh_ff[10:1]};
  wire rx_done = clk_fall && (bitcnt_ff == `PDSD_FRAME_LAST);
  wire [7:0] rx_byte = rx_shift[8:1];
  wire [7:0] id_cmd = `PDSD_CMD_IDENTIFY;

  // per-state time limit, one shared timer cleared on every state change
  wire [TW-1:0] lim_detach = TW'(DETACH_CYC - 1);
  wire [TW-1:0] lim_rx = TW'(RX_TO_CYC - 1);
  wire [TW-1:0] lim_inh = TW'(INHIBIT_CYC - 1);
  wire [TW-1:0] lim = (state_ff == pdsd_pkg::PDSD_ST_DETACH) ? lim_detach :
                      (state_ff == pdsd_pkg::PDSD_ST_INHIBIT) ? lim_inh : lim_rx;
  wire tmo = (timer_ff == lim);
  wire is_rx_state = (state_ff == pdsd_pkg::PDSD_ST_RX) || (state_ff == pdsd_pkg::PDSD_ST_RX_ACK) ||
                     (state_ff == pdsd_pkg::PDSD_ST_RX_ID0) || (state_ff == pdsd_pkg::PDSD_ST_RX_ID1);

  // sequencer next-state logic
  always_comb begin
    nxt_state = state_ff;
    nxt_bitcnt = bitcnt_ff;
    nxt_sh = sh_ff;
    nxt_id0 = id0_ff;
    nxt_attach = attach_ff;
    nxt_init = 1'b0;
    nxt_event = 1'b0;
    nxt_kbd = kbd_ff;
    nxt_clk_oe = clk_oe_ff;
    nxt_dat_oe = dat_oe_ff;
    if (is_rx_state && clk_fall) begin
      nxt_sh = rx_shift;
      nxt_bitcnt = bitcnt_ff + 4'h1;
    end
    case (state_ff)
      pdsd_pkg::PDSD_ST_IDLE: begin
        nxt_bitcnt = 4'h0;
        if (dat_fall) begin
          nxt_event = 1'b1;
          nxt_state = pdsd_pkg::PDSD_ST_RX;
        end
      end
      pdsd_pkg::PDSD_ST_RX: begin
        // received bytes are dropped here, translation lives elsewhere
        if (rx_done) begin
          nxt_state = pdsd_pkg::PDSD_ST_IDLE;
        end else if (tmo) begin
          nxt_state = dat_s2_ff ? pdsd_pkg::PDSD_ST_IDLE : pdsd_pkg::PDSD_ST_WAIT_ATT;
        end
      end
      pdsd_pkg::PDSD_ST_WAIT_ATT: begin
        if (clk_s2_ff && dat_s2_ff) begin
          nxt_clk_oe = 1'b1;
          nxt_state = pdsd_pkg::PDSD_ST_INHIBIT;
        end
      end
      pdsd_pkg::PDSD_ST_INHIBIT: begin
        // hold clock low, then claim the line with a start bit and hand the clock back
        if (tmo) begin
          nxt_clk_oe = 1'b0;
          nxt_dat_oe = 1'b1;
          nxt_sh = {1'b0, 1'b1, ~^id_cmd, id_cmd};
          nxt_bitcnt = 4'h0;
          nxt_state = pdsd_pkg::PDSD_ST_TX;
        end
      end
      pdsd_pkg::PDSD_ST_TX: begin
        // new bit on each falling edge; stop bit releases, the last fall is the peripheral's ack
        if (clk_fall) begin
          nxt_bitcnt = bitcnt_ff + 4'h1;
          nxt_dat_oe = ~sh_ff[0];
          nxt_sh = {1'b0, sh_ff[10:1]};
          if (bitcnt_ff == `PDSD_FRAME_LAST) begin
            nxt_dat_oe = 1'b0;
            nxt_bitcnt = 4'h0;
            nxt_state = pdsd_pkg::PDSD_ST_RX_ACK;
          end
        end else if (tmo) begin
          nxt_dat_oe = 1'b0;
          nxt_state = pdsd_pkg::PDSD_ST_WAIT_ATT;
        end
      end
      pdsd_pkg::PDSD_ST_RX_ACK: begin
        if (rx_done) begin
          nxt_bitcnt = 4'h0;
          nxt_state = (rx_byte == `PDSD_RSP_ACK) ? pdsd_pkg::PDSD_ST_RX_ID0 :
                      pdsd_pkg::PDSD_ST_WAIT_ATT;
        end else if (tmo) begin
          nxt_state = pdsd_pkg::PDSD_ST_WAIT_ATT;
        end
      end
      pdsd_pkg::PDSD_ST_RX_ID0: begin
        if (rx_done && rx_byte == KBD_ID0) begin
          nxt_bitcnt = 4'h0;
          nxt_id0 = rx_byte;
          nxt_state = pdsd_pkg::PDSD_ST_RX_ID1;
        end else if (rx_done || tmo) begin
          nxt_kbd = 1'b0;
          nxt_attach = 1'b0;
          nxt_state = pdsd_pkg::PDSD_ST_DETACH;
        end
      end
      pdsd_pkg::PDSD_ST_RX_ID1: begin
        if (rx_done || tmo) begin
          nxt_kbd = rx_done && (rx_byte == KBD_ID1) && (id0_ff == KBD_ID0);
          nxt_attach = 1'b0;
          nxt_state = pdsd_pkg::PDSD_ST_DETACH;
        end
      end
      pdsd_pkg::PDSD_ST_DETACH: begin
        if (tmo) begin
          nxt_attach = 1'b1;
          nxt_init = 1'b1;
          nxt_state = pdsd_pkg::PDSD_ST_REINIT;
        end
      end
      pdsd_pkg::PDSD_ST_REINIT: begin
        nxt_state = pdsd_pkg::PDSD_ST_IDLE;
      end
      default: begin
        nxt_state = pdsd_pkg::PDSD_ST_IDLE;
      end
    endcase
  end

  // sequencer registers
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_ff <= pdsd_pkg::PDSD_ST_IDLE;
      timer_ff <= '0;
      bitcnt_ff <= 4'h0;
      sh_ff <= 11'h000;
      id0_ff <= 8'h00;
      attach_ff <= 1'b1;
      init_ff <= 1'b0;
      event_ff <= 1'b0;
      kbd_ff <= 1'b0;
      clk_oe_ff <= 1'b0;
      dat_oe_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      timer_ff <= (nxt_state != state_ff || tmo) ? '0 : timer_ff + 1'b1;
      bitcnt_ff <= nxt_bitcnt;
      sh_ff <= nxt_sh;
      id0_ff <= nxt_id0;
      attach_ff <= nxt_attach;
      init_ff <= nxt_init;
      event_ff <= nxt_event;
      kbd_ff <= nxt_kbd;
      clk_oe_ff <= nxt_clk_oe;
      dat_oe_ff <= nxt_dat_oe;
    end
  end

  // open-drain port: only ever drives low
  assign port_clk_out = 1'b0;
  assign port_dat_out = 1'b0;
  assign port_clk_oe_out = clk_oe_ff;
  assign port_dat_oe_out = dat_oe_ff;
  assign usb_attach_enable_out = attach_ff;
  assign usb_interface_init_out = init_ff;
  assign data_fall_event_out = event_ff;
  assign keyboard_present_flag_out = kbd_ff;

  // descriptor start address and length by kind and set
  wire [`PDSD_ADDR_W-1:0] dev_addr = kbd_ff ? `PDSD_KB_DEV_ADDR : `PDSD_MS_DEV_ADDR;
  wire [`PDSD_ADDR_W-1:0] cfg_addr = kbd_ff ? `PDSD_KB_CFG_ADDR : `PDSD_MS_CFG_ADDR;
  wire [`PDSD_ADDR_W-1:0] rpt_addr = kbd_ff ? `PDSD_KB_RPT_ADDR : `PDSD_MS_RPT_ADDR;
  // strings sit in fixed slots by index, the flag is not consulted
  wire [`PDSD_ADDR_W-1:0] str_addr = `PDSD_STR_BASE +
                                     (`PDSD_ADDR_W'(desc_req_index_in) << `PDSD_STR_SHIFT);
  wire [7:0] cfg_len = kbd_ff ? `PDSD_KB_CFG_LEN : `PDSD_MS_CFG_LEN;
  wire [7:0] rpt_len = kbd_ff ? `PDSD_KB_RPT_LEN : `PDSD_MS_RPT_LEN;
  wire [`PDSD_ADDR_W-1:0] start_addr =
    (desc_req_kind_in == pdsd_pkg::PDSD_DESC_DEVICE) ? dev_addr :
    (desc_req_kind_in == pdsd_pkg::PDSD_DESC_CONFIG) ? cfg_addr :
    (desc_req_kind_in == pdsd_pkg::PDSD_DESC_REPORT) ? rpt_addr : str_addr;
  wire [7:0] start_len =
    (desc_req_kind_in == pdsd_pkg::PDSD_DESC_DEVICE) ? `PDSD_DEV_LEN :
    (desc_req_kind_in == pdsd_pkg::PDSD_DESC_CONFIG) ? cfg_len :
    (desc_req_kind_in == pdsd_pkg::PDSD_DESC_REPORT) ? rpt_len : `PDSD_STR_LEN;
  // string indexes past the last slot are accepted and produce nothing
  wire req_ok = (desc_req_kind_in != pdsd_pkg::PDSD_DESC_STRING) || (desc_req_index_in <= `PDSD_STR_MAX);

  logic srv_busy_ff;
  logic [`PDSD_ADDR_W-1:0] srv_addr_ff;
  logic [7:0] srv_left_ff;
  logic fifo_in_ready;
  pdsd_pkg::pdsd_desc_word_t push_word, pop_word;
  wire req_take = desc_req_valid_in && !srv_busy_ff;
  wire push = srv_busy_ff && fifo_in_ready;
  assign desc_req_ready_out = !srv_busy_ff;
  assign push_word.addr = srv_addr_ff;
  assign push_word.last = (srv_left_ff == 8'h01);

  // address stepper, stalls whenever the fifo is full
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      srv_busy_ff <= 1'b0;
      srv_addr_ff <= '0;
      srv_left_ff <= 8'h00;
    end else if (req_take) begin
      srv_busy_ff <= req_ok;
      srv_addr_ff <= start_addr;
      srv_left_ff <= start_len;
    end else if (push) begin
      srv_addr_ff <= srv_addr_ff + 1'b1;
      srv_left_ff <= srv_left_ff - 8'h01;
      srv_busy_ff <= !push_word.last;
    end
  end

  pdsd_fifo #(
    .W($bits(pdsd_pkg::pdsd_desc_word_t)),
    .D(FIFO_DEPTH)
  ) u_fifo (
    .clk_sys_in(clk_sys_in),
    .arst_n_in(arst_n_in),
    .in_valid_in(srv_busy_ff),
    .in_ready_out(fifo_in_ready),
    .in_data_in(push_word),
    .out_valid_out(desc_valid_out),
    .out_ready_in(desc_ready_in),
    .out_data_out(pop_word)
  );
  assign desc_addr_out = pop_word.addr;
  assign desc_last_out = pop_word.last;
endmodule : pdsd_top

// *** pdsd_top_checker.sv ***
// concurrent checks on the ports of the detect and soft detach sequencer
`timescale 1ns/1ps
`include "pdsd_regs.svh"
module pdsd_top_checker #(
  parameter int unsigned DETACH_CYC = `PDSD_DETACH_CYC
) (
  input wire logic clk_sys_in,
  input wire logic arst_n_in,
  input wire logic port_clk_in,
  input wire logic port_clk_out,
  input wire logic port_clk_oe_out,
  input wire logic port_dat_in,
  input wire logic port_dat_out,
  input wire logic port_dat_oe_out,
  input wire logic usb_attach_enable_out,
  input wire logic usb_interface_init_out,
  input wire logic data_fall_event_out,
  input wire logic keyboard_present_flag_out,
  input wire logic desc_req_valid_in,
  input wire logic desc_req_ready_out,
  input wire pdsd_pkg::pdsd_desc_kind_t desc_req_kind_in,
  input wire logic [3:0] desc_req_index_in,
  input wire logic desc_valid_out,
  input wire logic desc_ready_in,
  input wire logic [`PDSD_ADDR_W-1:0] desc_addr_out,
  input wire logic desc_last_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!arst_n_in);
  logic [31:0] low_cnt_ff;
  logic [31:0] nxt_low_cnt;
  logic take_idle;

  // cycles the pull-up has been off, so the detach length is checked exactly rather than by a long repetition
  assign nxt_low_cnt = usb_attach_enable_out ? 32'h0 : low_cnt_ff + 32'h1;
  assign take_idle = desc_req_valid_in && desc_req_ready_out && !desc_valid_out;
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      low_cnt_ff <= 32'h0;
    end else begin
      low_cnt_ff <= nxt_low_cnt;
    end
  end

  a_detach_starts: assert property ($fell(usb_attach_enable_out) |->
    (!usb_attach_enable_out && !usb_interface_init_out)[*8])
    else $error("attach enable did not stay off after a detach began");
  a_detach_length: assert property ($rose(usb_attach_enable_out) |-> low_cnt_ff == DETACH_CYC)
    else $error("attach enable off for the wrong number of cycles");
  a_reinit_follows: assert property ($rose(usb_attach_enable_out) |-> ##[0:2] usb_interface_init_out)
    else $error("no interface reinit after reconnect");
  a_init_pulse: assert property (usb_interface_init_out |->
    usb_attach_enable_out ##1 !usb_interface_init_out)
    else $error("interface reinit not a single pulse while attached");
  // the pin passes two sync stages into the event flop, three edges back; the edge stage only holds the old level
  a_fall_event: assert property (data_fall_event_out |->
    !$past(port_dat_in, 3) ##1 !data_fall_event_out)
    else $error("data fall event without a low data line or longer than a cycle");
  a_flag_at_detach: assert property ($changed(keyboard_present_flag_out) |->
    $fell(usb_attach_enable_out))
    else $error("keyboard flag changed outside a detach decision");
  a_open_drain: assert property (!port_clk_out && !port_dat_out &&
    !(port_clk_oe_out && port_dat_oe_out))
    else $error("port lines driven high or both pulled together");
  // string indexes past the last slot are taken without going busy, so they are left out here
  a_busy_after_take: assert property (desc_req_valid_in && desc_req_ready_out &&
    (desc_req_kind_in != pdsd_pkg::PDSD_DESC_STRING || desc_req_index_in <= 4'ha) |=> !desc_req_ready_out)
    else $error("request port still ready after taking a request");
  a_device_start: assert property (take_idle && desc_req_kind_in == pdsd_pkg::PDSD_DESC_DEVICE |-> ##2
    desc_valid_out && desc_addr_out == (keyboard_present_flag_out ? `PDSD_KB_DEV_ADDR : `PDSD_MS_DEV_ADDR))
    else $error("device descriptor start address wrong for the selected set");
  a_string_slot: assert property (take_idle && desc_req_kind_in == pdsd_pkg::PDSD_DESC_STRING &&
    desc_req_index_in <= 4'ha |-> ##2 desc_valid_out &&
    desc_addr_out == `PDSD_STR_BASE + {$past(desc_req_index_in, 2), 5'h00})
    else $error("string descriptor start address wrong");
  a_word_stands: assert property (desc_valid_out && !desc_ready_in |=>
    desc_valid_out && $stable(desc_addr_out) && $stable(desc_last_out))
    else $error("descriptor word changed while stalled");
endmodule : pdsd_top_checker

bind pdsd_top pdsd_top_checker #(.DETACH_CYC(DETACH_CYC)) u_checker (.*);

// *** pdsd_periph_model.sv ***
// behavioural keyboard or mouse on the two-wire port; it makes the port clock only inside frames
`timescale 1ns/1ps
module pdsd_periph_model #(
  parameter int HALF_NS = 100
) (
  input wire logic clk_oe_in,
  input wire logic dat_oe_in,
  input wire logic plugged_in,
  input wire logic two_ids_in,
  input wire logic [7:0] id0_in,
  input wire logic [7:0] id1_in,
  output logic port_clk_out,
  output logic port_dat_out,
  output logic [7:0] got_cmd_out
);
  logic clk_low = 1'b0;
  logic dat_low = 1'b0;
  logic [9:0] rx_bits;

  // wired-and of both open-drain parties; an empty socket leaves both lines low
  assign port_clk_out = plugged_in & ~clk_oe_in & ~clk_low;
  assign port_dat_out = plugged_in & ~dat_oe_in & ~dat_low;

  // one frame lsb first with odd parity, data changed while the clock is high
  task automatic send_byte(input logic [7:0] b);
    logic [10:0] f;
    f = {1'b1, ~^b, b, 1'b0};
    for (int i = 0; i < 11; i++) begin
      dat_low = ~f[i];
      #(HALF_NS) clk_low = 1'b1;
      #(HALF_NS) clk_low = 1'b0;
    end
    dat_low = 1'b0;
    #(2 * HALF_NS);
  endtask : send_byte

  // clock in the request, pulse the acknowledge, then answer with ack and id bytes
  always begin
    wait (plugged_in && dat_oe_in && !clk_oe_in);
    for (int i = 0; i < 10; i++) begin
      #(HALF_NS) clk_low = 1'b1;
      #(HALF_NS) rx_bits[i] = port_dat_out;
      clk_low = 1'b0;
    end
    got_cmd_out = rx_bits[7:0];
    #(HALF_NS / 2) dat_low = 1'b1;
    #(HALF_NS / 2) clk_low = 1'b1;
    #(HALF_NS) clk_low = 1'b0;
    #(HALF_NS / 2) dat_low = 1'b0;
    #(2 * HALF_NS);
    send_byte(8'hfa);
    send_byte(id0_in);
    if (two_ids_in) send_byte(id1_in);
  end
endmodule : pdsd_periph_model

// *** testbench.sv ***
// self-checking bench: peripheral swaps, soft detach timing and descriptor address streams
`timescale 1ns/1ps
`include "pdsd_regs.svh"
module testbench;
  localparam int unsigned DET = 200;
  localparam logic [7:0] ID0 = 8'h5a; // arbitrary value
  localparam logic [7:0] ID1 = 8'h3c; // arbitrary value
  logic clk_sys_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic port_clk_in, port_dat_in, port_clk_out, port_clk_oe_out, port_dat_out, port_dat_oe_out;
  logic usb_attach_enable_out, usb_interface_init_out, data_fall_event_out, keyboard_present_flag_out;
  logic desc_req_ready_out, desc_valid_out, desc_last_out;
  logic [9:0] desc_addr_out;
  logic desc_req_valid_in = 1'b0;
  logic desc_ready_in = 1'b0;
  logic [3:0] desc_req_index_in = 4'h0;
  pdsd_pkg::pdsd_desc_kind_t desc_req_kind_in = pdsd_pkg::PDSD_DESC_DEVICE;
  logic plugged = 1'b1;
  logic two_ids = 1'b0;
  logic [7:0] id0 = 8'h00;
  logic [7:0] id1 = 8'h00;
  logic [7:0] got_cmd;
  int n_fail = 0;
  int total_checks = 0;

  // 200 mhz system clock
  always #2.5 clk_sys_in = ~clk_sys_in;

  // short detach, timeout and inhibit counts keep the run brief
  pdsd_top #(.DETACH_CYC(DET), .RX_TO_CYC(2000), .INHIBIT_CYC(50), .KBD_ID0(ID0), .KBD_ID1(ID1)) u_dut (.*);
  pdsd_periph_model u_periph (.clk_oe_in(port_clk_oe_out), .dat_oe_in(port_dat_oe_out), .plugged_in(plugged),
    .two_ids_in(two_ids), .id0_in(id0), .id1_in(id1), .port_clk_out(port_clk_in), .port_dat_out(port_dat_in),
    .got_cmd_out(got_cmd));

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : wrap_up

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  function automatic logic pick(input int sel);
    case (sel)
      0: return usb_attach_enable_out;
      1: return data_fall_event_out;
      2: return port_clk_oe_out;
      default: return usb_interface_init_out;
    endcase
  endfunction : pick

  // bounded wait on a design output, sampled on falling clock edges
  task automatic wait_for(input int sel, input logic val, input int lim);
    int i;
    for (i = 0; i < lim && pick(sel) !== val; i++) @(negedge clk_sys_in);
    if (i == lim) begin
      n_fail++;
      $display("Error at %0t: wait %h never saw %h", $time, sel, val);
      wrap_up();
    end
  endtask : wait_for

  // unplug, let the reception time out, then plug in a peripheral answering with the given id bytes
  task automatic swap_periph(input logic [7:0] a, input logic [7:0] b, input logic two, input logic exp_kb);
    int n;
    @(posedge clk_sys_in);
    #1;
    id0 = a;
    id1 = b;
    two_ids = two;
    plugged = 1'b0;
    wait_for(1, 1'b1, 20);
    @(negedge clk_sys_in);
    check(data_fall_event_out, 1'b0);
    repeat (2200) @(negedge clk_sys_in);
    check({usb_attach_enable_out, port_clk_oe_out, port_dat_oe_out}, 3'b100);
    @(posedge clk_sys_in);
    #1;
    plugged = 1'b1;
    wait_for(2, 1'b1, 20);
    wait_for(0, 1'b0, 5000);
    check({got_cmd, keyboard_present_flag_out}, {8'hf2, exp_kb});
    for (n = 0; n < 2 * DET && usb_attach_enable_out === 1'b0; n++) @(negedge clk_sys_in);
    check(n, DET);
    wait_for(3, 1'b1, 3);
  endtask : swap_periph

  // one request, optional stall with the fifo filling, then drain and compare every address
  task automatic desc_check(input pdsd_pkg::pdsd_desc_kind_t k, input logic [3:0] idx, input logic [9:0] st,
    input logic [7:0] len, input int stall);
    int i;
    int n;
    @(posedge clk_sys_in);
    #1;
    desc_req_kind_in = k;
    desc_req_index_in = idx;
    desc_req_valid_in = 1'b1;
    desc_ready_in = 1'b0;
    for (i = 0; i < 50 && desc_req_ready_out !== 1'b1; i++) @(negedge clk_sys_in);
    @(posedge clk_sys_in);
    #1;
    desc_req_valid_in = 1'b0;
    repeat (stall) @(negedge clk_sys_in);
    if (stall > 0) check({desc_valid_out, desc_req_ready_out, desc_addr_out}, {2'b10, st});
    // drain opens just after a rising edge so the first word is still there at the next sample
    @(posedge clk_sys_in);
    #1;
    desc_ready_in = 1'b1;
    n = 0;
    for (i = 0; i < len + 40; i++) begin
      @(negedge clk_sys_in);
      if (desc_valid_out === 1'b1) begin
        check({desc_last_out, desc_addr_out}, {n == len - 1, 10'(st + n)});
        n++;
      end
    end
    check(n, len);
  endtask : desc_check

  task automatic desc_set(input logic kb);
    desc_check(pdsd_pkg::PDSD_DESC_DEVICE, 4'h0, kb ? `PDSD_KB_DEV_ADDR : `PDSD_MS_DEV_ADDR, `PDSD_DEV_LEN, 30);
    desc_check(pdsd_pkg::PDSD_DESC_CONFIG, 4'h0, kb ? `PDSD_KB_CFG_ADDR : `PDSD_MS_CFG_ADDR,
      kb ? `PDSD_KB_CFG_LEN : `PDSD_MS_CFG_LEN, 0);
    desc_check(pdsd_pkg::PDSD_DESC_REPORT, 4'h0, kb ? `PDSD_KB_RPT_ADDR : `PDSD_MS_RPT_ADDR,
      kb ? `PDSD_KB_RPT_LEN : `PDSD_MS_RPT_LEN, 0);
    for (int s = 0; s < 16; s++) begin
      desc_check(pdsd_pkg::PDSD_DESC_STRING, 4'(s), 10'(`PDSD_STR_BASE + s * 32), s > 10 ? 8'h00 : `PDSD_STR_LEN, 0);
    end
  endtask : desc_set

  // main sequence: reset, mouse, keyboard, keyboard with a wrong second id byte
  initial begin
    repeat (3) @(posedge clk_sys_in);
    #1;
    arst_n_in = 1'b1;
    @(negedge clk_sys_in);
    check({usb_attach_enable_out, keyboard_present_flag_out, port_clk_oe_out, port_dat_oe_out, desc_valid_out,
      desc_req_ready_out}, 6'h21);
    swap_periph(8'h00, 8'h00, 1'b0, 1'b0);
    swap_periph(ID0, ID1, 1'b1, 1'b1);
    desc_set(1'b1);
    swap_periph(ID0, 8'h00, 1'b1, 1'b0);
    desc_set(1'b0);
    wrap_up();
  end

  // watchdog: a hang counts as a mismatch
  initial begin
    #200us;
    n_fail++;
    $display("Error at %0t: watchdog expired", $time);
    wrap_up();
  end
endmodule : testbench
